// ### trace_capture_regs.svh
// Purpose: Offsets, field positions, reset values and timing counts of the trace capture block
// Assumes: 32-bit register port, word indexed, 100 MHz clock
// Notes:   Definitions only
`ifndef TRACE_CAPTURE_REGS_SVH
`define TRACE_CAPTURE_REGS_SVH
`define TC_CTRL_ADDR     8'h00
`define TC_CH_SEL_ADDR   8'h01
`define TC_THRESH_ADDR   8'h02
`define TC_CFG_ADDR      8'h03
`define TC_PERIOD_ADDR   8'h04
`define TC_STATUS_ADDR   8'h05
`define TC_FAULT_ADDR    8'h06
`define TC_PEAK_ADDR     8'h07
`define TC_BUF_IDX_ADDR  8'h08
`define TC_BUF_DATA_ADDR 8'h09
`define TC_TRIG_IDX_ADDR 8'h0a
// Control register command bits (write one to act)
`define TC_CMD_ARM       0
`define TC_CMD_STOP      1
`define TC_CMD_RUN       2
`define TC_CMD_UFAULT    3
`define TC_CMD_FCLR      4
`define TC_CMD_PKCLR     5
`define TC_CMD_ENA       6
`define TC_CMD_DIS       7
// Config fields
`define TC_CFG_EDGE_LSB  0
`define TC_CFG_CONT_BIT  2
`define TC_CFG_PCT_LSB   8
`define TC_CFG_DBL_LSB   16
`define TC_CFG_TSEL_LSB  20
`define TC_CFG_EN_LSB    24
// Sample period in units of 0.125 ms (1 .. 65528)
`define TC_TICK_US       125
`define TC_TICK_CYC      ((`TC_TICK_US * 1000) / 10)
`define TC_PERIOD_MIN    16'h0001
`define TC_PERIOD_MAX    16'hfff8
`define TC_PERIOD_RST    16'h0010
`define TC_STORE_WORDS   600
`endif

// ### trace_capture_pkg.sv
// Purpose: Types shared by the trace capture block
// Assumes: Used with trace_capture_regs.svh
// Notes:   Types only
package trace_capture_pkg;
  typedef enum logic [1:0] {EDGE_IMMEDIATE, EDGE_RISING, EDGE_FALLING, EDGE_RSVD} trig_edge_t;
  typedef enum logic [2:0] {TS_IDLE, TS_RUNNING, TS_WAITING, TS_FILLING, TS_DONE} trig_state_t;
  typedef enum logic [1:0] {FL_NONE, FL_WARNING, FL_DISABLING} fault_level_t;
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } reg_req_t;
  typedef struct packed {
    logic [3:0]  warn;
    logic [3:0]  flt;
  } fault_src_t;
endpackage

// ### trace_capture.sv
// Purpose: Trace capture, trigger, fault and enable status logic of a servo drive
// Assumes: Monitored variables come from same-clock logic; hw enable and fault causes are pins
// Notes:   Register port, reads answered one cycle after the strobe
`timescale 1ns/10ps
`default_nettype none
`include "trace_capture_regs.svh"
module trace_capture
  import trace_capture_pkg::*;
#(
  parameter int NVARS      = 16,                // Monitored drive variables
  parameter int WORDS      = `TC_STORE_WORDS,   // Shared capture store depth
  parameter int TICK_CYC   = `TC_TICK_CYC       // Cycles per 0.125 ms tick
) (
  input  wire logic                      clock,      // 100 MHz clock
  input  wire logic                      nrst,       // Async reset, active low
  input  wire trace_capture_pkg::reg_req_t req,      // Register request
  output logic [31:0]                    rdata,      // Read data, cycle after read
  input  wire logic [NVARS*32-1:0]       vars,       // Monitored variables
  input  wire logic                      hw_enable,  // Hardware enable pin
  input  wire trace_capture_pkg::fault_src_t causes, // Fault and warning cause pins
  output logic                           drive_en,   // Drive enabled
  output logic                           refused     // Last enable request refused
);
  import trace_capture_pkg::*;

  localparam int IW = $clog2(WORDS);
  localparam int VW = $clog2(NVARS);

  // Pin synchronisers
  logic [1:0] hwen_s_r;
  logic [7:0] cause_m_r, cause_s_r;
  wire        hwen = hwen_s_r[1];
  wire  [3:0] warn_now = cause_s_r[7:4];
  wire  [3:0] flt_now  = cause_s_r[3:0];

  // Configuration
  logic [4*VW-1:0] ch_sel_r;
  logic [31:0]     thresh_r;
  logic [1:0]      edge_r;
  logic            cont_r;
  logic [6:0]      pct_r;
  logic [3:0]      dbl_r;
  logic [3:0]      chen_r;
  logic [VW-1:0]   tsel_r;
  logic [15:0]     period_r;

  // Capture state
  trig_state_t     st_r, st_nxt;
  logic [31:0]     store_r [WORDS];
  logic [IW-1:0]   wptr_r, trig_ptr_r, rdidx_r;
  logic [IW:0]     pre_cnt_r, post_cnt_r;
  logic [31:0]     prev_r;
  logic            prev_ok_r;
  logic [31:0]     tick_cnt_r;
  logic [15:0]     per_cnt_r;

  // Faults and drive
  logic [3:0]      flt_r, warn_r;
  logic            ufault_r;
  logic [31:0]     peak_r;
  logic [31:0]     rdata_r;

  function automatic logic [31:0] var_at(input logic [NVARS*32-1:0] v, input logic [VW-1:0] i);
    var_at = v[i*32 +: 32];
  endfunction

  // Word of a channel inside a row; sparse enables must not spill into the next row
  function automatic int slot_of(input logic [3:0] en, input int c);
    slot_of = 0;
    for (int j = 0; j < c; j++)
      slot_of += int'(en[j]);
  endfunction

  // Decode
  wire wr_ctrl = req.wr && (req.addr == `TC_CTRL_ADDR);
  wire cmd_arm  = wr_ctrl && req.wdata[`TC_CMD_ARM];
  wire cmd_stop = wr_ctrl && req.wdata[`TC_CMD_STOP];
  wire cmd_run  = wr_ctrl && req.wdata[`TC_CMD_RUN];
  wire cmd_uflt = wr_ctrl && req.wdata[`TC_CMD_UFAULT];
  wire cmd_fclr = wr_ctrl && req.wdata[`TC_CMD_FCLR];
  wire cmd_pclr = wr_ctrl && req.wdata[`TC_CMD_PKCLR];
  wire cmd_ena  = wr_ctrl && req.wdata[`TC_CMD_ENA];
  wire cmd_dis  = wr_ctrl && req.wdata[`TC_CMD_DIS];
  wire stopped  = (st_r == TS_IDLE) || (st_r == TS_DONE);

  // Words per sample and entries; one word per enabled channel, two if double
  wire [3:0] wps = 4'({3'b0, chen_r[0]} + {3'b0, chen_r[1]} + {3'b0, chen_r[2]}
                   + {3'b0, chen_r[3]} + {3'b0, chen_r[0] & dbl_r[0]}
                   + {3'b0, chen_r[1] & dbl_r[1]} + {3'b0, chen_r[2] & dbl_r[2]}
                   + {3'b0, chen_r[3] & dbl_r[3]});
  wire [IW:0] entries = (wps == 4'h0) ? (IW+1)'(0) : (IW+1)'(WORDS / int'(wps));
  wire [IW:0] used    = (IW+1)'(int'(entries) * int'(wps));
  wire [IW:0] pre_need = (IW+1)'((int'(entries) * int'(pct_r)) / 100);
  wire [IW:0] post_need = entries - pre_need;

  // Sample tick: period counted in 0.125 ms units
  wire tick = (tick_cnt_r == 32'(TICK_CYC - 1));
  wire sample = tick && (per_cnt_r <= 16'h0001) && (st_r != TS_IDLE) && (st_r != TS_DONE)
                && (st_r != TS_RUNNING);

  // Trigger evaluation, signed compare
  wire [31:0] tval = var_at(vars, tsel_r);
  wire rise = prev_ok_r && ($signed(tval) > $signed(prev_r))
              && ($signed(tval) >= $signed(thresh_r));
  wire fall = prev_ok_r && ($signed(tval) < $signed(prev_r))
              && ($signed(tval) <= $signed(thresh_r));
  wire pre_ok = (pre_cnt_r >= pre_need);
  wire hit = pre_ok && ((edge_r == 2'(EDGE_IMMEDIATE)) ||
             ((edge_r == 2'(EDGE_RISING)) && rise) ||
             ((edge_r == 2'(EDGE_FALLING)) && fall));
  wire last_post = (post_cnt_r + 1'b1 >= post_need);

  always_comb
  begin
    st_nxt = st_r;
    unique case (st_r)
      TS_IDLE, TS_DONE:
        if (cmd_arm && (wps != 4'h0))
          st_nxt = TS_WAITING;
        else if (cmd_run)
          st_nxt = TS_RUNNING;
      TS_RUNNING:
        ;
      TS_WAITING:
        if (sample && hit)
          st_nxt = (post_need <= 1) ? (cont_r ? TS_WAITING : TS_DONE) : TS_FILLING;
      TS_FILLING:
        if (sample && last_post)
          st_nxt = cont_r ? TS_WAITING : TS_DONE;
      default:
        st_nxt = TS_IDLE;
    endcase
    if (cmd_stop)
      st_nxt = TS_IDLE;
  end

  // Pins pass two flip-flops before any logic reads them
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      hwen_s_r  <= 2'b00;
      cause_m_r <= 8'h00;
      cause_s_r <= 8'h00;
    end
    else
    begin
      hwen_s_r  <= {hwen_s_r[0], hw_enable};
      cause_m_r <= causes;
      cause_s_r <= cause_m_r;
    end
  end

  // Configuration writes; channel selection is only safe while stopped
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      ch_sel_r <= '0;
      thresh_r <= 32'h0000_0000;
      edge_r   <= 2'b01;
      cont_r   <= 1'b0;
      pct_r    <= 7'h00;
      dbl_r    <= 4'h0;
      chen_r   <= 4'h1;
      tsel_r   <= '0;
      period_r <= `TC_PERIOD_RST;
      rdidx_r  <= '0;
    end
    else if (req.wr)
    begin
      if (req.addr == `TC_CH_SEL_ADDR)
        ch_sel_r <= req.wdata[4*VW-1:0];
      if (req.addr == `TC_THRESH_ADDR)
        thresh_r <= req.wdata;
      if (req.addr == `TC_CFG_ADDR)
      begin
        edge_r <= req.wdata[`TC_CFG_EDGE_LSB +: 2];
        cont_r <= req.wdata[`TC_CFG_CONT_BIT];
        pct_r  <= (req.wdata[`TC_CFG_PCT_LSB +: 7] > 7'd100) ? 7'd100
                  : req.wdata[`TC_CFG_PCT_LSB +: 7];
        dbl_r  <= req.wdata[`TC_CFG_DBL_LSB +: 4];
        tsel_r <= req.wdata[`TC_CFG_TSEL_LSB +: VW];
        chen_r <= req.wdata[`TC_CFG_EN_LSB +: 4];
      end
      if (req.addr == `TC_PERIOD_ADDR)
        period_r <= (req.wdata[15:0] < `TC_PERIOD_MIN) ? `TC_PERIOD_MIN
                    : (req.wdata[15:0] > `TC_PERIOD_MAX) ? `TC_PERIOD_MAX : req.wdata[15:0];
      if (req.addr == `TC_BUF_IDX_ADDR)
        rdidx_r <= req.wdata[IW-1:0];
    end
  end

  // Tick and period counters
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      tick_cnt_r <= 32'h0000_0000;
      per_cnt_r  <= 16'h0001;
    end
    else
    begin
      tick_cnt_r <= tick ? 32'h0000_0000 : tick_cnt_r + 1'b1;
      if (cmd_arm)
        per_cnt_r <= 16'h0001;
      else if (tick)
        per_cnt_r <= (per_cnt_r <= 16'h0001) ? period_r : per_cnt_r - 1'b1;
    end
  end

  // Capture engine: circular writes while waiting
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      st_r       <= TS_IDLE;
      wptr_r     <= '0;
      trig_ptr_r <= '0;
      pre_cnt_r  <= '0;
      post_cnt_r <= '0;
      prev_r     <= 32'h0000_0000;
      prev_ok_r  <= 1'b0;
    end
    else
    begin
      st_r <= st_nxt;
      if ((st_nxt == TS_WAITING) && (st_r != TS_WAITING && st_r != TS_FILLING))
      begin
        wptr_r    <= '0;
        pre_cnt_r <= '0;
        prev_ok_r <= 1'b0;
      end
      else if (sample)
      begin
        prev_r    <= tval;
        prev_ok_r <= 1'b1;
        wptr_r    <= (wptr_r + IW'(wps) >= IW'(used)) ? '0 : wptr_r + IW'(wps);
        if (st_r == TS_WAITING)
        begin
          if (hit)
          begin
            trig_ptr_r <= wptr_r;
            post_cnt_r <= (IW+1)'(1);
            pre_cnt_r  <= '0;
          end
          else if (pre_cnt_r < entries)
            pre_cnt_r <= pre_cnt_r + 1'b1;
        end
        else
          post_cnt_r <= post_cnt_r + 1'b1;
      end
    end
  end

  // One packed row per sample; every enabled channel is stored, shown or not
  always_ff @(posedge clock)
  begin
    if (sample)
      for (int c = 0; c < 4; c++)
        if (chen_r[c])
          store_r[(int'(wptr_r) + slot_of(chen_r, c)) % WORDS]
            <= var_at(vars, ch_sel_r[c*VW +: VW]);
  end

  // Faults: latched, relatched while cause remains
  wire [3:0] flt_set = flt_now;
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      flt_r    <= 4'h0;
      warn_r   <= 4'h0;
      ufault_r <= 1'b0;
      drive_en <= 1'b0;
      refused  <= 1'b0;
      peak_r   <= 32'h0000_0000;
    end
    else
    begin
      flt_r    <= (cmd_fclr ? 4'h0 : flt_r) | flt_set;
      warn_r   <= (cmd_fclr ? 4'h0 : warn_r) | warn_now;
      ufault_r <= cmd_uflt | (ufault_r & ~cmd_fclr);
      if (!hwen || (flt_r != 4'h0) || ufault_r || cmd_uflt || cmd_dis)
        drive_en <= 1'b0;
      else if (cmd_ena)
        drive_en <= 1'b1;
      if (cmd_ena)
        refused <= !hwen || (flt_r != 4'h0) || ufault_r;
      if (cmd_pclr)
        peak_r <= 32'h0000_0000;
      else if ($signed(tval) > $signed(peak_r))
        peak_r <= tval;
    end
  end

  wire disabling = (flt_r != 4'h0) || ufault_r;
  wire [1:0] flevel = disabling ? 2'(FL_DISABLING)
                    : (warn_r != 4'h0) ? 2'(FL_WARNING) : 2'(FL_NONE);

  // Read mux
  wire [31:0] rd_mux =
    (req.addr == `TC_CH_SEL_ADDR)   ? 32'(ch_sel_r) :
    (req.addr == `TC_THRESH_ADDR)   ? thresh_r :
    (req.addr == `TC_CFG_ADDR)      ? (32'(edge_r) | (32'(cont_r) << `TC_CFG_CONT_BIT)
                                      | (32'(pct_r) << `TC_CFG_PCT_LSB)
                                      | (32'(dbl_r) << `TC_CFG_DBL_LSB)
                                      | (32'(tsel_r) << `TC_CFG_TSEL_LSB)
                                      | (32'(chen_r) << `TC_CFG_EN_LSB)) :
    (req.addr == `TC_PERIOD_ADDR)   ? 32'(period_r) :
    (req.addr == `TC_STATUS_ADDR)   ? (32'(st_r) | (32'(entries) << 16)) :
    (req.addr == `TC_FAULT_ADDR)    ? (32'(flevel) | (32'(flt_r) << 4) | (32'(warn_r) << 8)
                                      | (32'(ufault_r) << 12) | (32'(drive_en) << 16)
                                      | (32'(refused) << 17) | (32'(hwen) << 18)) :
    (req.addr == `TC_PEAK_ADDR)     ? peak_r :
    (req.addr == `TC_BUF_IDX_ADDR)  ? 32'(rdidx_r) :
    (req.addr == `TC_BUF_DATA_ADDR) ? store_r[rdidx_r] :
    (req.addr == `TC_TRIG_IDX_ADDR) ? 32'(trig_ptr_r) : 32'h0000_0000;

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      rdata_r <= 32'h0000_0000;
    else
      rdata_r <= req.rd ? rd_mux : 32'h0000_0000;
  end
  assign rdata = rdata_r;

  AST_STOP_IDLE: assert property (@(posedge clock) disable iff (!nrst)
    cmd_stop |=> (st_r == TS_IDLE)) else $error("stop did not idle");
  AST_SINGLE_DONE: assert property (@(posedge clock) disable iff (!nrst)
    (st_r == TS_FILLING && sample && last_post && !cont_r && !cmd_stop) |=> (st_r == TS_DONE))
    else $error("single capture did not end");
  AST_CONT_REARM: assert property (@(posedge clock) disable iff (!nrst)
    (st_r == TS_FILLING && sample && last_post && cont_r && !cmd_stop) |=> (st_r == TS_WAITING))
    else $error("continuous did not rearm");
  AST_UFAULT_DIS: assert property (@(posedge clock) disable iff (!nrst)
    cmd_uflt |=> !drive_en) else $error("user fault left drive enabled");
  AST_REFUSE: assert property (@(posedge clock) disable iff (!nrst)
    (cmd_ena && !hwen) |=> (refused && !drive_en)) else $error("enable not refused");
  AST_LEVEL: assert property (@(posedge clock) disable iff (!nrst)
    (flt_now != 4'h0) |=> (flevel == 2'(FL_DISABLING))) else $error("bad fault level");
  AST_PEAK: assert property (@(posedge clock) disable iff (!nrst)
    cmd_pclr |=> (peak_r == 32'h0000_0000)) else $error("peak not cleared");
  AST_RELATCH: assert property (@(posedge clock) disable iff (!nrst)
    (cmd_fclr && flt_now != 4'h0) |=> (flt_r != 4'h0)) else $error("fault lost on clear");
  AST_ARM: assert property (@(posedge clock) disable iff (!nrst)
    (stopped && cmd_arm && !cmd_stop && wps != 4'h0) |=> (st_r == TS_WAITING))
    else $error("arm ignored");
endmodule // trace_capture
`default_nettype wire

// ### workstation_link.sv
// Purpose: Workstation side of the register port, issuing register writes, reads and commands
// Assumes: One clock, one-cycle strobes, read data stand only in the cycle after the strobe
// Notes:   Released address and data are inverted so stale values never look valid
`timescale 1ns/10ps
`default_nettype none
`include "trace_capture_regs.svh"
module workstation_link
(
  input  wire logic                   clock, // Bench clock
  output var trace_capture_pkg::reg_req_t req,   // Request to the drive
  input  wire logic [31:0]            rdata  // Read data from the drive
);
  import trace_capture_pkg::*;
  logic capture_on;  // Capture started by this side and not yet stopped

  initial
  begin
    req = '0;
    capture_on = 1'b0;
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clock);
    req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge clock);
    req <= '{addr: ~a, wdata: ~v, wr: 1'b0, rd: 1'b0};
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clock);
    req <= '{addr: a, wdata: 32'h0000_0000, wr: 1'b0, rd: 1'b1};
    @(posedge clock);
    req <= '{addr: ~a, wdata: 32'hffff_ffff, wr: 1'b0, rd: 1'b0};
    #1;
    v = rdata;
  endtask

  task automatic cmd(input int b);
    wr(`TC_CTRL_ADDR, 32'h0000_0001 << b);
    if (b == `TC_CMD_ARM)
      capture_on = 1'b1;
    else if (b == `TC_CMD_STOP)
      capture_on = 1'b0;
  endtask

  // Selection moves only while stopped, so a stop goes out first if needed
  task automatic select(input logic [31:0] v);
    if (capture_on)
      cmd(`TC_CMD_STOP);
    wr(`TC_CH_SEL_ADDR, v);
  endtask
endmodule // workstation_link
`default_nettype wire

// ### drive_trace_trigger_capture_test.sv
// Purpose: Self-checking bench of the trace capture block
// Assumes: Short tick parameter; workstation_link speaks the register port
// Notes:   Variable 3 is the trigger variable; the low three carry random noise
`timescale 1ns/10ps
`default_nettype none
`include "trace_capture_regs.svh"
module drive_trace_trigger_capture_test;
  import trace_capture_pkg::*;
  localparam int NV = 16;
  localparam int TK = 4;  // Short tick keeps one capture to a few hundred cycles
  logic             clock = 1'b0;
  logic             nrst;
  logic             hw_enable;
  fault_src_t       causes;
  reg_req_t         req;
  logic [31:0]      rdata;
  logic [31:0]      trig_val;
  logic [95:0]      noise;
  wire [NV*32-1:0]  vars;
  logic             drive_en;
  logic             refused;
  logic [31:0]      d;
  logic [31:0]      thr;
  logic [2:0]       prev;
  int               bad_count;
  int               samples_checked;
  int               seed;
  int               fills;
  int               el;
  int               s;
  time              t0;
  logic [3:0]       ens [4] = '{4'h1, 4'h3, 4'h1, 4'hf};
  logic [3:0]       dbls [4] = '{4'h0, 4'h0, 4'h1, 4'hf};
  int               pcts [4] = '{0, 50, 100, 0};
  int               pers [4] = '{1, 1, 1, 3};
  int               offs [4] = '{2, -2, -1, 0};

  assign vars = {{(NV - 4){32'h0000_5a5a}}, trig_val, noise};
  always #5 clock = ~clock;
  always @(posedge clock) noise <= {$random(seed), $random(seed), $random(seed)};

  trace_capture #(.NVARS(NV), .WORDS(`TC_STORE_WORDS), .TICK_CYC(TK)) u_trace_capture (
    .clock(clock), .nrst(nrst), .req(req), .rdata(rdata), .vars(vars),
    .hw_enable(hw_enable), .causes(causes), .drive_en(drive_en), .refused(refused));
  workstation_link u_workstation_link (.clock(clock), .req(req), .rdata(rdata));

  function automatic logic [31:0] cfg(input logic [1:0] e, input logic c, input logic [6:0] p,
                                     input logic [3:0] en, input logic [3:0] dbl);
    return {4'h0, en, 4'h3, dbl, 1'b0, p, 5'h00, c, e};
  endfunction

  function automatic logic [31:0] ents(input logic [3:0] en, input logic [3:0] dbl);
    int w;
    w = 0;
    for (int i = 0; i < 4; i++)
      w += en[i] ? (dbl[i] ? 2 : 1) : 0;
    return `TC_STORE_WORDS / w;
  endfunction

  task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic check_bit(input logic got, input logic exp);
    check_word({31'h0, got}, {31'h0, exp});
  endtask

  task automatic check_state(input trig_state_t st);
    u_workstation_link.rd(`TC_STATUS_ADDR, d);
    check_word({29'h0, d[2:0]}, {29'h0, st});
  endtask

  task automatic fault_is(input logic [31:0] exp);
    u_workstation_link.rd(`TC_FAULT_ADDR, d);
    check_word(d & 32'h0000_1003, exp);
  endtask

  task automatic ticks(input int n);
    repeat (n * TK) @(posedge clock);
    #1;
  endtask

  task automatic tally_and_finish;
    $display("Comparisons %0d, mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  initial
  begin
    #300000;
    bad_count++;
    tally_and_finish();
  end

  initial
  begin
    seed = 32'hc83e2811;
    nrst = 1'b0;
    hw_enable = 1'b0;
    causes = '0;
    trig_val = 32'h0000_0000;
    bad_count = 0;
    samples_checked = 0;
    repeat (20) @(posedge clock);
    nrst <= 1'b1;
    check_state(TS_IDLE);
    u_workstation_link.rd(`TC_PERIOD_ADDR, d);
    check_word(d & 32'h0000_ffff, {16'h0000, `TC_PERIOD_RST});
    u_workstation_link.rd(8'h3f, d);
    check_word(d, 32'h0000_0000);
    fault_is(32'h0000_0000);
    check_bit(drive_en, 1'b0);
    u_workstation_link.select(32'h0000_4321);
    u_workstation_link.rd(`TC_CH_SEL_ADDR, d);
    check_word(d & 32'h0000_ffff, 32'h0000_4321);
    u_workstation_link.wr(`TC_THRESH_ADDR, 32'h8000_0000);
    u_workstation_link.rd(`TC_THRESH_ADDR, d);
    check_word(d, 32'h8000_0000);
    for (int k = 0; k < 4; k++)
    begin
      u_workstation_link.wr(`TC_CFG_ADDR, cfg(2'd0, 1'b0, 7'd0, ens[k], dbls[k]));
      u_workstation_link.rd(`TC_STATUS_ADDR, d);
      check_word({16'h0000, d[31:16]}, ents(ens[k], dbls[k]));
    end
    // Four double channels give 75 entries, so a capture lasts 75 periods
    for (int k = 0; k < 4; k++)
    begin
      u_workstation_link.wr(`TC_PERIOD_ADDR, pers[k]);
      u_workstation_link.wr(`TC_CFG_ADDR, cfg(2'd0, 1'b0, pcts[k][6:0], 4'hf, 4'hf));
      u_workstation_link.cmd(`TC_CMD_ARM);
      t0 = $time;
      ticks(10 * pers[k]);
      check_state(pcts[k] == 0 ? TS_FILLING : TS_WAITING);
      d = 32'h0000_0000;
      for (int i = 0; i < 2000 && d[2:0] != 3'(TS_DONE); i++)
        u_workstation_link.rd(`TC_STATUS_ADDR, d);
      el = int'(($time - t0) / 10);
      check_bit(el inside {[75 * TK * pers[k] - 12 * pers[k] : 75 * TK * pers[k] + 12 * pers[k] + 8]}, 1'b1);
      ticks(20 * pers[k]);
      check_state(TS_DONE);
      u_workstation_link.cmd(`TC_CMD_STOP);
    end
    u_workstation_link.wr(`TC_PERIOD_ADDR, 32'h0000_0001);
    for (int m = 1; m < 3; m++)
      for (int k = 0; k < 2; k++)
      begin
        s = (m == 1) ? 4 : -4;
        thr = k ? 32'h8000_0100 : $random(seed) >>> 4;
        u_workstation_link.wr(`TC_CFG_ADDR, cfg(m[1:0], 1'b0, 7'd0, 4'h1, 4'h0));
        u_workstation_link.wr(`TC_THRESH_ADDR, thr);
        // Steady, then wrong way, then right way but short, then reaching the threshold
        for (int ph = 0; ph < 4; ph++)
        begin
          trig_val <= thr + offs[ph] * s;
          ticks(10);
          if (ph == 0)
            u_workstation_link.cmd(`TC_CMD_ARM);
          if (ph == 0)
            ticks(10);
          check_state(ph == 3 ? TS_FILLING : TS_WAITING);
        end
        u_workstation_link.cmd(`TC_CMD_STOP);
        check_state(TS_IDLE);
      end
    u_workstation_link.wr(`TC_CFG_ADDR, cfg(2'd0, 1'b1, 7'd0, 4'hf, 4'hf));
    u_workstation_link.cmd(`TC_CMD_ARM);
    fills = 0;
    prev = 3'd0;
    repeat (800)
    begin
      u_workstation_link.rd(`TC_STATUS_ADDR, d);
      if (d[2:0] == 3'(TS_FILLING) && prev != 3'(TS_FILLING))
        fills++;
      prev = d[2:0];
    end
    check_bit(fills >= 2, 1'b1);
    u_workstation_link.cmd(`TC_CMD_STOP);
    check_state(TS_IDLE);
    u_workstation_link.cmd(`TC_CMD_RUN);
    check_state(TS_RUNNING);
    u_workstation_link.cmd(`TC_CMD_STOP);
    check_state(TS_IDLE);
    // Channels B and D only: their words sit side by side in each row
    trig_val <= $random(seed);
    u_workstation_link.select(32'h0000_5030);
    u_workstation_link.wr(`TC_CFG_ADDR, cfg(2'd0, 1'b0, 7'd0, 4'ha, 4'h0));
    u_workstation_link.cmd(`TC_CMD_ARM);
    ticks(310);
    check_state(TS_DONE);
    u_workstation_link.wr(`TC_BUF_IDX_ADDR, 32'h0000_0000);
    u_workstation_link.rd(`TC_BUF_DATA_ADDR, d);
    check_word(d, trig_val);
    u_workstation_link.wr(`TC_BUF_IDX_ADDR, 32'h0000_0001);
    u_workstation_link.rd(`TC_BUF_DATA_ADDR, d);
    check_word(d, 32'h0000_5a5a);
    u_workstation_link.rd(`TC_TRIG_IDX_ADDR, d);
    check_word(d, 32'h0000_0000);
    trig_val <= 32'h0000_0000;
    ticks(2);
    u_workstation_link.cmd(`TC_CMD_PKCLR);
    u_workstation_link.rd(`TC_PEAK_ADDR, d);
    check_word(d, 32'h0000_0000);
    u_workstation_link.cmd(`TC_CMD_ENA);
    ticks(1);
    check_bit(refused, 1'b1);
    check_bit(drive_en, 1'b0);
    hw_enable <= 1'b1;
    ticks(1);
    u_workstation_link.cmd(`TC_CMD_ENA);
    ticks(1);
    check_bit(drive_en, 1'b1);
    u_workstation_link.cmd(`TC_CMD_DIS);
    ticks(1);
    check_bit(drive_en, 1'b0);
    causes <= '{warn: 4'h1, flt: 4'h2};
    ticks(1);
    fault_is(32'h0000_0002);
    u_workstation_link.cmd(`TC_CMD_ENA);
    ticks(1);
    check_bit(refused, 1'b1);
    u_workstation_link.cmd(`TC_CMD_FCLR);
    ticks(1);
    fault_is(32'h0000_0002);
    causes <= '{warn: 4'h1, flt: 4'h0};
    ticks(1);
    fault_is(32'h0000_0002);
    u_workstation_link.cmd(`TC_CMD_FCLR);
    ticks(1);
    fault_is(32'h0000_0001);
    causes <= '0;
    ticks(1);
    u_workstation_link.cmd(`TC_CMD_FCLR);
    ticks(1);
    fault_is(32'h0000_0000);
    u_workstation_link.cmd(`TC_CMD_ENA);
    ticks(1);
    check_bit(drive_en, 1'b1);
    u_workstation_link.cmd(`TC_CMD_UFAULT);
    repeat (2) @(posedge clock);
    #1;
    check_bit(drive_en, 1'b0);
    fault_is(32'h0000_1002);
    u_workstation_link.cmd(`TC_CMD_FCLR);
    ticks(1);
    fault_is(32'h0000_0000);
    tally_and_finish();
  end
endmodule // drive_trace_trigger_capture_test
`default_nettype wire
